/* File: hw/aps_pkg.sv */
// Shared constants for the negotiation partner status register bank
package aps_pkg;
   localparam int APB_ADDR_W = 12;
   localparam int APB_DATA_W = 32;
   localparam int REG_W      = 16;

   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_PARTNER_ABILITY = 10'h146;
   localparam logic [9:0] IDX_EXPANSION       = 10'h148;
   localparam logic [9:0] IDX_TEST            = 10'h14a;

   // Partner ability fields
   localparam int ABL_NEXT_PAGE    = 15;
   localparam int ABL_ACK          = 14;
   localparam int ABL_REMOTE_FAULT = 13;
   localparam int ABL_RSV_HI       = 12;
   localparam int ABL_RSV_LO       = 11;
   localparam int ABL_PAUSE        = 10;
   localparam int ABL_TECH_HI      = 9;
   localparam int ABL_TECH_LO      = 5;
   localparam int ABL_SEL_HI       = 4;
   localparam logic [15:0] ABILITY_MASK = 16'he7ff;
   localparam logic [15:0] ABILITY_RST  = 16'h0000;

   // Expansion fields
   localparam int EXP_RSV_LO   = 5;
   localparam int EXP_MLF      = 4;
   localparam int EXP_LP_NP    = 3;
   localparam int EXP_LOCAL_NP = 2;
   localparam int EXP_PAGE_RX  = 1;
   localparam int EXP_LP_NW    = 0;

   // Sticky expansion event slots
   localparam int EV_W    = 3;
   localparam int EV_MLF  = 2;
   localparam int EV_PAGE = 1;
   localparam int EV_NW   = 0;

   // Test register fields; visited flags sit in bits 2..0
   localparam int TST_LOOPBACK = 7;
   localparam int TST_LED_SEL  = 3;
   localparam int TST_ABD      = 2;
   localparam int TST_PDF      = 1;
   localparam int TST_LSC      = 0;
   localparam int VIS_W        = 3;
endpackage : aps_pkg

/* File: hw/aps_sync.sv */
// Two-stage synchroniser for pins entering the pclk domain
`timescale 1ns/10ps
module aps_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } aps_sync_state_t;

   aps_sync_state_t st;
   aps_sync_state_t next_st;

   // The meta stage feeds only the second stage
   always_comb begin
      next_st.meta = async_in;
      next_st.sync = st.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.sync;
endmodule : aps_sync

/* File: hw/aps_sticky.sv */
// Bank of sticky flags where a set beats a simultaneous clear
`timescale 1ns/10ps
module aps_sticky #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] flags;
   } aps_sticky_state_t;

   aps_sticky_state_t st;
   aps_sticky_state_t next_st;

   always_comb begin
      next_st = st;
      for (int i = 0; i < W; i++) begin
         if (set[i]) begin
            next_st.flags[i] = 1'b1;
         end else if (clr[i]) begin
            next_st.flags[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;
endmodule : aps_sticky

/* File: hw/aps_regs.sv */
// APB register bank for negotiation partner ability, expansion and test status
`timescale 1ns/10ps
// How it works
// - Ability bit 15: partner wants next page
// - Bit 14 set by partner acknowledge from bursts, held until the next page or a restart
// - Bit 13 tracks partner remote fault
// - Bit 10 partner pause, bits 12-11 zero
// - Bits 9-5 hold partner technology abilities
// - Bits 4-0 partner selector, reset zero
// - Expansion bits 15-5 always read zero
// - Expansion bit 4 flags multiple link fault
// - Expansion bit 3: partner next page capable
// - Expansion bit 2: local next page, reset zero
// - Expansion bit 1 set on new page
// - Reading ability register clears page flag
// - Expansion bit 0: partner negotiates
// - Test bit 7 writable loopback control
// - Test bit 3 routes link pulses to LED
// - Test bit 2 records ability detect visit
// - Test bit 1 records parallel fault visit
// - Test bit 0 records link check visit
// - Restart clears partner and expansion contents except expansion bit 2 (local next page)
module aps_regs (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [aps_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [aps_pkg::APB_DATA_W-1:0] pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic      [aps_pkg::APB_DATA_W-1:0] prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [aps_pkg::REG_W-1:0]      page_word,
   input  wire logic                           page_strobe,
   input  wire logic                           partner_ack_detect,
   input  wire logic                           partner_nw_detect,
   input  wire logic                           link_fault_event,
   input  wire logic                           local_next_page_capable,
   input  wire logic                           restart_negotiation,
   input  wire logic                           phy_ctrl_reset,
   input  wire logic                           visit_ability_detect,
   input  wire logic                           visit_parallel_fault,
   input  wire logic                           visit_link_check,
   input  wire logic                           link_pulse_pin,
   input  wire logic                           normal_led,
   output logic                                negotiation_loopback,
   output logic                                first_led_output
);
   import aps_pkg::*;

   typedef struct packed {
      logic [REG_W-1:0]      ability;
      logic                  local_np;
      logic                  loopback;
      logic                  led_sel;
      logic                  led;
      logic                  fresh_page;
      logic [APB_DATA_W-1:0] rdata;
   } aps_regs_state_t;

   aps_regs_state_t st;
   aps_regs_state_t next_st;

   logic             sel_pa;
   logic             sel_exp;
   logic             sel_test;
   logic             hit;
   logic             setup;
   logic             access_wr;
   logic             access_rd;
   logic             rd_pa_access;
   logic             page_clr;
   logic             link_pulse_sync;
   logic [EV_W-1:0]  ev_set;
   logic [EV_W-1:0]  ev_clr;
   logic [EV_W-1:0]  ev_flags;
   logic [VIS_W-1:0] vis_set;
   logic [VIS_W-1:0] vis_clr;
   logic [VIS_W-1:0] visited;
   logic [REG_W-1:0] expansion_value;
   logic [REG_W-1:0] test_value;
   logic [REG_W-1:0] rd_value;

   // Address decode; misaligned addresses match nothing
   assign sel_pa   = (paddr[1:0] == 2'b00) && (paddr[APB_ADDR_W-1:2] == IDX_PARTNER_ABILITY);
   assign sel_exp  = (paddr[1:0] == 2'b00) && (paddr[APB_ADDR_W-1:2] == IDX_EXPANSION);
   assign sel_test = (paddr[1:0] == 2'b00) && (paddr[APB_ADDR_W-1:2] == IDX_TEST);
   assign hit      = sel_pa | sel_exp | sel_test;

   // Zero wait states; read data is snapshotted in the setup cycle
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit;
   assign setup     = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   assign access_rd = psel & penable & ~pwrite;
   assign rd_pa_access = access_rd & sel_pa;

   // A page landing after the snapshot must not be lost by the read
   assign page_clr = rd_pa_access & ~st.fresh_page;

   aps_sync #(
      .W (1)
   ) u_pulse_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (link_pulse_pin),
      .sync_out (link_pulse_sync)
   );

   always_comb begin
      ev_set         = '0;
      ev_clr         = {EV_W{restart_negotiation}};
      ev_set[EV_MLF] = link_fault_event;
      ev_set[EV_PAGE] = page_strobe;
      ev_set[EV_NW]  = partner_nw_detect;
      ev_clr[EV_PAGE] = restart_negotiation | page_clr;
   end

   aps_sticky #(
      .W (EV_W)
   ) u_exp_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (ev_set),
      .clr     (ev_clr),
      .flags   (ev_flags)
   );

   always_comb begin
      vis_set          = '0;
      vis_set[TST_ABD] = visit_ability_detect;
      vis_set[TST_PDF] = visit_parallel_fault;
      vis_set[TST_LSC] = visit_link_check;
      vis_clr          = {VIS_W{phy_ctrl_reset}};
   end

   aps_sticky #(
      .W (VIS_W)
   ) u_visited (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (vis_set),
      .clr     (vis_clr),
      .flags   (visited)
   );

   always_comb begin
      expansion_value               = '0;
      expansion_value[EXP_MLF]      = ev_flags[EV_MLF];
      expansion_value[EXP_LP_NP]    = st.ability[ABL_NEXT_PAGE];
      expansion_value[EXP_LOCAL_NP] = st.local_np;
      expansion_value[EXP_PAGE_RX]  = ev_flags[EV_PAGE];
      expansion_value[EXP_LP_NW]    = ev_flags[EV_NW];
      test_value                    = '0;
      test_value[TST_LOOPBACK]      = st.loopback;
      test_value[TST_LED_SEL]       = st.led_sel;
      test_value[VIS_W-1:0]         = visited;
      rd_value                      = '0;
      if (sel_pa) begin
         rd_value = st.ability;
      end else if (sel_exp) begin
         rd_value = expansion_value;
      end else if (sel_test) begin
         rd_value = test_value;
      end
   end

   always_comb begin
      next_st          = st;
      next_st.local_np = local_next_page_capable;
      next_st.led      = st.led_sel ? link_pulse_sync : normal_led;
      if (setup) begin
         next_st.rdata      = {{(APB_DATA_W-REG_W){1'b0}}, rd_value};
         next_st.fresh_page = page_strobe;
      end else if (page_strobe) begin
         next_st.fresh_page = 1'b1;
      end
      // Only the two control bits of the test register accept writes
      if (access_wr && sel_test && pstrb[0]) begin
         next_st.loopback = pwdata[TST_LOOPBACK];
         next_st.led_sel  = pwdata[TST_LED_SEL];
      end
      if (partner_ack_detect) begin
         next_st.ability[ABL_ACK] = 1'b1;
      end
      if (restart_negotiation) begin
         next_st.ability = ABILITY_RST;
      end
      // A fresh base page outranks a restart in the same cycle
      if (page_strobe) begin
         next_st.ability = page_word & ABILITY_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata               = st.rdata;
   assign negotiation_loopback = st.loopback;
   assign first_led_output     = st.led;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_NP_CAPTURE: assert property (
      page_strobe |=> st.ability[ABL_NEXT_PAGE] == $past(page_word[ABL_NEXT_PAGE]))
      else $error("next page bit not captured");

   AST_ACK_SET: assert property (
      partner_ack_detect && !page_strobe && !restart_negotiation |=> st.ability[ABL_ACK])
      else $error("acknowledge bit not set");

   AST_RF_TRACK: assert property (
      page_strobe |=> st.ability[ABL_REMOTE_FAULT] == $past(page_word[ABL_REMOTE_FAULT]))
      else $error("remote fault bit wrong");

   AST_RSV_ZERO: assert property (
      st.ability[ABL_RSV_HI:ABL_RSV_LO] == 2'b00 ##1 st.ability[ABL_RSV_HI:ABL_RSV_LO] == 2'b00)
      else $error("reserved ability bits set");

   AST_TECH_CAPTURE: assert property (
      page_strobe |=> st.ability[ABL_TECH_HI:ABL_TECH_LO] == $past(page_word[ABL_TECH_HI:ABL_TECH_LO]))
      else $error("technology bits wrong");

   AST_SEL_CAPTURE: assert property (
      page_strobe |=> st.ability[ABL_SEL_HI:0] == $past(page_word[ABL_SEL_HI:0]))
      else $error("selector bits wrong");

   AST_EXP_UPPER: assert property (
      setup && sel_exp |=> prdata[APB_DATA_W-1:EXP_RSV_LO] == '0)
      else $error("expansion upper bits not zero");

   AST_MLF_SET: assert property (
      link_fault_event |=> ev_flags[EV_MLF])
      else $error("multiple link fault not flagged");

   AST_LP_NP_READ: assert property (
      setup && sel_exp |=> prdata[EXP_LP_NP] == $past(st.ability[ABL_NEXT_PAGE]))
      else $error("partner next page bit wrong");

   AST_LOCAL_NP: assert property (
      ##1 st.local_np == $past(local_next_page_capable))
      else $error("local next page bit not tracked");

   AST_PAGE_SET: assert property (
      page_strobe |=> ev_flags[EV_PAGE])
      else $error("page received not set");

   AST_PAGE_CLEAR: assert property (
      rd_pa_access && !st.fresh_page && !page_strobe |=> !ev_flags[EV_PAGE])
      else $error("page received not cleared by read");

   AST_NW_SET: assert property (
      partner_nw_detect |=> ev_flags[EV_NW])
      else $error("partner negotiation ability not set");

   AST_LOOPBACK_WR: assert property (
      access_wr && sel_test && pstrb[0] |=> negotiation_loopback == $past(pwdata[TST_LOOPBACK]))
      else $error("loopback write lost");

   AST_LED_PULSE: assert property (
      st.led_sel && $past(st.led_sel) |-> first_led_output == $past(link_pulse_sync))
      else $error("LED does not follow link pulses");

   AST_VIS_ABD: assert property (
      visit_ability_detect |=> visited[TST_ABD])
      else $error("ability detect visit not flagged");

   AST_VIS_PDF: assert property (
      visit_parallel_fault |=> visited[TST_PDF])
      else $error("parallel fault visit not flagged");

   AST_VIS_LSC: assert property (
      visit_link_check |=> visited[TST_LSC])
      else $error("link check visit not flagged");

   AST_RESTART: assert property (
      restart_negotiation && !page_strobe && !link_fault_event && !partner_nw_detect
      |=> st.ability == ABILITY_RST && ev_flags == '0)
      else $error("restart left partner contents");

   AST_RO_WRITE: assert property (
      access_wr && sel_pa && !page_strobe && !partner_ack_detect && !restart_negotiation
      |=> $stable(st.ability))
      else $error("write changed read-only ability");

   AST_VIS_HOLD: assert property (
      !phy_ctrl_reset |=> (visited & $past(visited)) == $past(visited))
      else $error("visited flag dropped without reset");

   AST_ACK_CAPTURE: assert property (
      page_strobe |=> st.ability[ABL_ACK] == $past(page_word[ABL_ACK]))
      else $error("acknowledge bit not loaded from page");

   AST_RESTART_ACK: assert property (
      partner_ack_detect && restart_negotiation && !page_strobe |=> !st.ability[ABL_ACK])
      else $error("acknowledge survived restart");

   AST_PAUSE_CAPTURE: assert property (
      page_strobe |=> st.ability[ABL_PAUSE] == $past(page_word[ABL_PAUSE]))
      else $error("pause bit wrong");

   AST_LOCAL_NP_READ: assert property (
      setup && sel_exp |=> prdata[EXP_LOCAL_NP] == $past(st.local_np))
      else $error("local next page bit not read back");

   AST_PAGE_KEEP: assert property (
      rd_pa_access && st.fresh_page && !restart_negotiation |=> ev_flags[EV_PAGE])
      else $error("page flag lost to a read");

   AST_LOOPBACK_HOLD: assert property (
      !(access_wr && sel_test && pstrb[0]) |=> $stable(negotiation_loopback))
      else $error("loopback changed without a write");

   AST_LED_NORMAL: assert property (
      !st.led_sel |=> first_led_output == $past(normal_led))
      else $error("LED does not follow normal indication");

   AST_VIS_READ: assert property (
      setup && sel_test |=> prdata[VIS_W-1:0] == $past(visited))
      else $error("visited flags not read back");

   AST_PAGE_BEATS_RESTART: assert property (
      page_strobe && restart_negotiation |=> st.ability == ($past(page_word) & ABILITY_MASK))
      else $error("restart overrode a new page");

   AST_TEST_UPPER: assert property (
      setup && sel_test |=> prdata[APB_DATA_W-1:TST_LOOPBACK+1] == '0)
      else $error("test register upper bits not zero");

   AST_VIS_CLEAR: assert property (
      phy_ctrl_reset && !visit_ability_detect && !visit_parallel_fault && !visit_link_check
      |=> visited == '0)
      else $error("visited flags not cleared");

endmodule : aps_regs

/* File: tb/aps_partner_model.sv */
// Behavioural link partner that feeds decoded negotiation events to the bank
`timescale 1ns/10ps
module aps_partner_model (
   input  wire logic        pclk,
   output logic      [15:0] page_word,
   output logic             page_strobe,
   output logic             partner_ack_detect,
   output logic             partner_nw_detect,
   output logic             link_fault_event,
   output logic             link_pulse_pin
);
   initial begin
      page_word = 16'h0000;
      page_strobe = 1'b0;
      {link_fault_event, partner_nw_detect, partner_ack_detect} = 3'b000;
      link_pulse_pin = 1'b0;
   end

   // Word lines show the inverse of the last page once the strobe is gone,
   // so a bank that samples outside the strobe picks up garbage
   task automatic send_page(input logic [15:0] w);
      @(posedge pclk);
      page_word <= w;
      page_strobe <= 1'b1;
      @(posedge pclk);
      page_word <= ~w;
      page_strobe <= 1'b0;
   endtask : send_page

   // Index 0 acknowledge, 1 partner negotiates, 2 multiple link fault
   task automatic event_pulse(input int k);
      @(posedge pclk);
      {link_fault_event, partner_nw_detect, partner_ack_detect} <= 3'b001 << k;
      @(posedge pclk);
      {link_fault_event, partner_nw_detect, partner_ack_detect} <= 3'b000;
   endtask : event_pulse

   task automatic set_pulse(input logic lvl);
      @(posedge pclk);
      link_pulse_pin <= lvl;
   endtask : set_pulse
endmodule : aps_partner_model

/* File: tb/aps_regs_tb.sv */
// Self-checking bench for the negotiation status register bank
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t: got %h want %h", $time, g, e); end end
module aps_regs_tb;
   localparam logic [11:0] A_ABL = {aps_pkg::IDX_PARTNER_ABILITY, 2'b00};
   localparam logic [11:0] A_EXP = {aps_pkg::IDX_EXPANSION, 2'b00};
   localparam logic [11:0] A_TST = {aps_pkg::IDX_TEST, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [3:0]  pstrb;
   logic [15:0] page_word;
   logic        page_strobe, ack_det, nw_det, fault_ev, pulse_pin, lnp, normal_led, loopback, led;
   logic [4:0]  ctl;
   int          n_errors, check_count, cycles;

   aps_regs i_aps_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .page_word(page_word), .page_strobe(page_strobe),
      .partner_ack_detect(ack_det), .partner_nw_detect(nw_det), .link_fault_event(fault_ev),
      .local_next_page_capable(lnp), .restart_negotiation(ctl[0]), .phy_ctrl_reset(ctl[1]),
      .visit_ability_detect(ctl[2]), .visit_parallel_fault(ctl[3]), .visit_link_check(ctl[4]),
      .link_pulse_pin(pulse_pin), .normal_led(normal_led), .negotiation_loopback(loopback),
      .first_led_output(led)
   );

   aps_partner_model i_aps_partner_model (
      .pclk(pclk), .page_word(page_word), .page_strobe(page_strobe),
      .partner_ack_detect(ack_det), .partner_nw_detect(nw_det),
      .link_fault_event(fault_ev), .link_pulse_pin(pulse_pin)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Whole run is about 150 cycles; the ceiling only catches a hung handshake
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse(input int b);
      @(posedge pclk);
      ctl <= 5'h01 << b;
      @(posedge pclk);
      ctl <= 5'h00;
   endtask : pulse

   task automatic t_reset_values();
      apb(1'b0, A_ABL, 32'h0);
      `CHK(v, 32'h0000_0000)
      `CHK(err, 1'b0)
      `CHK(pready, 1'b1)
      apb(1'b0, A_EXP, 32'h0);
      `CHK(v, 32'h0000_0000)
      apb(1'b0, A_TST, 32'h0);
      `CHK(v, 32'h0000_0000)
      apb(1'b0, 12'h52c, 32'h0);
      `CHK(err, 1'b1)
   endtask : t_reset_values

   task automatic t_pages();
      logic [15:0] words [2] = '{16'hffff, 16'h0d41};
      for (int i = 0; i < 2; i++) begin
         i_aps_partner_model.send_page(words[i]);
         apb(1'b0, A_EXP, 32'h0);
         `CHK(v, {27'h0, 1'b0, words[i][15], 1'b0, 1'b1, 1'b0})
         apb(1'b0, A_ABL, 32'h0);
         `CHK(v, {16'h0, words[i] & 16'he7ff})
         apb(1'b0, A_EXP, 32'h0);
         `CHK(v[1], 1'b0)
      end
      i_aps_partner_model.send_page(16'h0000);
      i_aps_partner_model.event_pulse(0);
      apb(1'b0, A_ABL, 32'h0);
      `CHK(v, 32'h0000_4000)
      // A page landing in the setup cycle of a read must survive that read
      fork
         apb(1'b0, A_ABL, 32'h0);
         i_aps_partner_model.send_page(16'h0021);
      join
      `CHK(v, 32'h0000_4000)
      apb(1'b0, A_EXP, 32'h0);
      `CHK(v, 32'h0000_0002)
      apb(1'b0, A_ABL, 32'h0);
      `CHK(v, 32'h0000_0021)
   endtask : t_pages

   task automatic t_events();
      @(posedge pclk);
      lnp <= 1'b1;
      i_aps_partner_model.event_pulse(1);
      i_aps_partner_model.event_pulse(2);
      apb(1'b0, A_EXP, 32'h0);
      `CHK(v, 32'h0000_0015)
      pulse(0);
      apb(1'b0, A_ABL, 32'h0);
      `CHK(v, 32'h0000_0000)
      apb(1'b0, A_EXP, 32'h0);
      `CHK(v, 32'h0000_0004)
   endtask : t_events

   task automatic t_test_reg();
      logic [31:0] want;
      want = 32'h0;
      for (int b = 0; b < 3; b++) begin
         pulse(2 + b);
         want = want | (32'h4 >> b);
         apb(1'b0, A_TST, 32'h0);
         `CHK(v, want)
      end
      repeat (20) @(posedge pclk);
      apb(1'b0, A_TST, 32'h0);
      `CHK(v, 32'h0000_0007)
      apb(1'b1, A_ABL, 32'hffff_ffff);
      apb(1'b1, A_EXP, 32'hffff_ffff);
      apb(1'b1, A_TST, 32'hffff_ffff);
      // Without the low byte strobe the control bits must keep their values
      pstrb <= 4'he;
      apb(1'b1, A_TST, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, A_TST, 32'h0);
      `CHK(v, 32'h0000_008f)
      `CHK(loopback, 1'b1)
      apb(1'b0, A_ABL, 32'h0);
      `CHK(v, 32'h0000_0000)
      apb(1'b0, A_EXP, 32'h0);
      `CHK(v, 32'h0000_0004)
      pulse(1);
      apb(1'b0, A_TST, 32'h0);
      `CHK(v, 32'h0000_0088)
   endtask : t_test_reg

   // Pin passes two synchroniser flops and the output register before the LED
   task automatic t_led();
      @(posedge pclk);
      normal_led <= 1'b1;
      i_aps_partner_model.set_pulse(1'b1);
      repeat (4) @(posedge pclk);
      `CHK(led, 1'b1)
      i_aps_partner_model.set_pulse(1'b0);
      repeat (4) @(posedge pclk);
      `CHK(led, 1'b0)
      apb(1'b1, A_TST, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      `CHK(led, 1'b1)
      `CHK(loopback, 1'b0)
   endtask : t_led

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      lnp = 1'b0;
      normal_led = 1'b0;
      ctl = 5'h00;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_pages();
      t_events();
      t_test_reg();
      t_led();
      give_verdict();
   end
endmodule : aps_regs_tb
